// [psl_regs.svh]
// bit positions, field widths, codes and timing figures of the serial latch block
// assumes: included by the package and by the design module through its bare name
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

`define PSL_WORD_W 24
`define PSL_SEL_HI 1
`define PSL_SEL_LO 0
`define PSL_SEL_CONFIG 2'h0
`define PSL_SEL_FEEDBACK 2'h2
`define PSL_SEL_REFERENCE 2'h1

// configuration word
`define PSL_CFG_PRESC_HI 23
`define PSL_CFG_PRESC_LO 22
`define PSL_CFG_PD_MODE 21
`define PSL_CFG_PD_REQ 20
`define PSL_CFG_CUR2_HI 19
`define PSL_CFG_CUR2_LO 17
`define PSL_CFG_CUR1_HI 16
`define PSL_CFG_CUR1_LO 14
`define PSL_CFG_OPWR_HI 13
`define PSL_CFG_OPWR_LO 12
`define PSL_CFG_MUTE 11
`define PSL_CFG_GAIN 10
`define PSL_CFG_TRISTATE 9
`define PSL_CFG_POLARITY 8
`define PSL_CFG_MUX_HI 7
`define PSL_CFG_MUX_LO 5
`define PSL_CFG_CLEAR 4
`define PSL_CFG_CPWR_HI 3
`define PSL_CFG_CPWR_LO 2

// feedback divider word
`define PSL_FB_HALVED_SEL 23
`define PSL_FB_HALVING 22
`define PSL_FB_GAIN 21
`define PSL_FB_MAIN_HI 20
`define PSL_FB_MAIN_LO 8
`define PSL_FB_SWALLOW_HI 6
`define PSL_FB_SWALLOW_LO 2
`define PSL_MAIN_W 13
`define PSL_SWALLOW_W 5

// reference divider word
`define PSL_REF_BAND_HI 21
`define PSL_REF_BAND_LO 20
`define PSL_REF_TEST 19
`define PSL_REF_PRECISION 18
`define PSL_REF_ABP_HI 17
`define PSL_REF_ABP_LO 16
`define PSL_REF_DIV_HI 15
`define PSL_REF_DIV_LO 2
`define PSL_REF_W 14

// timing
`define PSL_CLK_PERIOD_NS 10
`define PSL_PHASE_WINDOW_NS 15
`define PSL_PHASE_CYCLES (((`PSL_PHASE_WINDOW_NS / `PSL_CLK_PERIOD_NS) < 1) ? 1 : \
	(`PSL_PHASE_WINDOW_NS / `PSL_CLK_PERIOD_NS))
`define PSL_PHASE_CNT_W 4
`define PSL_LOCK_FINE 3'h5
`define PSL_LOCK_COARSE 3'h3
`define PSL_SYNC_PD_EDGES 2'h2

`endif

// [psl_pkg.sv]
// types shared by the serial latch block: latch images and power-down states
// assumes: psl_regs.svh sits in the same folder
`include "psl_regs.svh"

package psl_pkg;

	typedef enum logic [1:0] {
		PSL_RUN,
		PSL_WAIT_REF,
		PSL_DOWN
	} psl_pd_e;

	typedef struct packed {
		logic [1:0] prescalerSel;
		logic powerdownSyncMode;
		logic powerdownRequest;
		logic [2:0] pumpCurrentTwo;
		logic [2:0] pumpCurrentOne;
		logic [1:0] outputPower;
		logic muteUntilLocked;
		logic pumpThreeState;
		logic detectorPolarity;
		logic [2:0] monitorMuxSel;
		logic dividerCountersClear;
		logic [1:0] corePower;
	} psl_cfg_s;

	typedef struct packed {
		logic halvedFeedbackSel;
		logic outputHalving;
		logic [`PSL_MAIN_W-1:0] mainCount;
		logic [`PSL_SWALLOW_W-1:0] swallowCount;
	} psl_fb_s;

	typedef struct packed {
		logic [1:0] bandClockDivider;
		logic factoryTestFlag;
		logic lockPrecisionSel;
		logic [1:0] antibacklashWidth;
		logic [`PSL_REF_W-1:0] referenceDivide;
	} psl_ref_s;

endpackage : psl_pkg

// [psl_serial_latch.sv]
// serial latch block: three-wire word capture, latch decode, power-down sequencing,
// reference and dual-modulus feedback counters and digital lock detect
// assumes: serialClk is the host's shift clock and may stop between words; refIn,
// prescalerIn, chipEnable and loadStrobe are asynchronous pins
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_serial_latch
	import psl_pkg::*;
(
	// system clock, synchronous reset, clock enable
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	// three-wire serial link
	input wire logic serialClk,
	input wire logic serialData,
	input wire logic loadStrobe,
	// device pins
	input wire logic chipEnable,
	input wire logic refIn,
	input wire logic prescalerIn,
	// analogue controls
	output psl_cfg_s configImage,
	output psl_fb_s feedbackImage,
	output psl_ref_s referenceImage,
	output logic pumpGainSelect,
	output logic [2:0] pumpCurrent,
	output logic pumpTristate,
	output logic detectorPositive,
	output logic rfMute,
	output logic outputHalving,
	output logic halvedFeedbackSel,
	output logic modulusHigh,
	output logic referenceBufferEnable,
	// status
	output logic poweredDown,
	output logic referencePulse,
	output logic feedbackPulse,
	output logic lockDetect
);

	function automatic logic [`PSL_REF_W-1:0] countNext(input logic [`PSL_REF_W-1:0] cnt,
		input logic [`PSL_REF_W-1:0] limit);
		countNext = (cnt + 14'h0001 >= limit) ? 14'h0000 : cnt + 14'h0001;
	endfunction : countNext

	// serial link domain: shift register only, no reset needed for data
	logic [`PSL_WORD_W-1:0] shiftWord;

	always_ff @(posedge serialClk) begin
		shiftWord <= {shiftWord[`PSL_WORD_W-2:0], serialData};
	end

	// two-flop synchronisers for asynchronous pins
	logic [1:0] strobeSync_q, strobeSync_d;
	logic [1:0] ceSync_q, ceSync_d;
	logic [1:0] refSync_q, refSync_d;
	logic [1:0] preSync_q, preSync_d;
	logic strobeLast_q, strobeLast_d;
	logic refLast_q, refLast_d;
	logic preLast_q, preLast_d;

	always_comb begin
		strobeSync_d = {strobeSync_q[0], loadStrobe};
		ceSync_d = {ceSync_q[0], chipEnable};
		refSync_d = {refSync_q[0], refIn};
		preSync_d = {preSync_q[0], prescalerIn};
		strobeLast_d = strobeSync_q[1];
		refLast_d = refSync_q[1];
		preLast_d = preSync_q[1];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			strobeSync_q <= 2'h0;
			ceSync_q <= 2'h0;
			refSync_q <= 2'h0;
			preSync_q <= 2'h0;
			strobeLast_q <= 1'b0;
			refLast_q <= 1'b0;
			preLast_q <= 1'b0;
		end else if (clkEn) begin
			strobeSync_q <= strobeSync_d;
			ceSync_q <= ceSync_d;
			refSync_q <= refSync_d;
			preSync_q <= preSync_d;
			strobeLast_q <= strobeLast_d;
			refLast_q <= refLast_d;
			preLast_q <= preLast_d;
		end
	end

	// the shift word is quiet while the strobe is high, so it is read after the sync
	logic loadRise;
	logic refEdge;
	logic preEdge;
	logic [1:0] latchSel;
	assign loadRise = strobeSync_q[1] & ~strobeLast_q;
	assign refEdge = refSync_q[1] & ~refLast_q;
	assign preEdge = preSync_q[1] & ~preLast_q;
	assign latchSel = {shiftWord[`PSL_SEL_HI], shiftWord[`PSL_SEL_LO]};

	// latch images
	psl_cfg_s cfg_q, cfg_d;
	psl_fb_s fb_q, fb_d;
	psl_ref_s ref_q, ref_d;
	logic gain_q, gain_d;

	always_comb begin
		cfg_d = cfg_q;
		fb_d = fb_q;
		ref_d = ref_q;
		gain_d = gain_q;
		if (loadRise) begin
			case (latchSel)
				`PSL_SEL_CONFIG: begin
					cfg_d.prescalerSel = shiftWord[`PSL_CFG_PRESC_HI:`PSL_CFG_PRESC_LO];
					cfg_d.powerdownSyncMode = shiftWord[`PSL_CFG_PD_MODE];
					cfg_d.powerdownRequest = shiftWord[`PSL_CFG_PD_REQ];
					cfg_d.pumpCurrentTwo = shiftWord[`PSL_CFG_CUR2_HI:`PSL_CFG_CUR2_LO];
					cfg_d.pumpCurrentOne = shiftWord[`PSL_CFG_CUR1_HI:`PSL_CFG_CUR1_LO];
					cfg_d.outputPower = shiftWord[`PSL_CFG_OPWR_HI:`PSL_CFG_OPWR_LO];
					cfg_d.muteUntilLocked = shiftWord[`PSL_CFG_MUTE];
					cfg_d.pumpThreeState = shiftWord[`PSL_CFG_TRISTATE];
					cfg_d.detectorPolarity = shiftWord[`PSL_CFG_POLARITY];
					cfg_d.monitorMuxSel = shiftWord[`PSL_CFG_MUX_HI:`PSL_CFG_MUX_LO];
					cfg_d.dividerCountersClear = shiftWord[`PSL_CFG_CLEAR];
					cfg_d.corePower = shiftWord[`PSL_CFG_CPWR_HI:`PSL_CFG_CPWR_LO];
					gain_d = shiftWord[`PSL_CFG_GAIN];
				end
				`PSL_SEL_FEEDBACK: begin
					fb_d.halvedFeedbackSel = shiftWord[`PSL_FB_HALVED_SEL];
					fb_d.outputHalving = shiftWord[`PSL_FB_HALVING];
					fb_d.mainCount = shiftWord[`PSL_FB_MAIN_HI:`PSL_FB_MAIN_LO];
					fb_d.swallowCount = shiftWord[`PSL_FB_SWALLOW_HI:`PSL_FB_SWALLOW_LO];
					gain_d = shiftWord[`PSL_FB_GAIN];
				end
				`PSL_SEL_REFERENCE: begin
					ref_d.bandClockDivider = shiftWord[`PSL_REF_BAND_HI:`PSL_REF_BAND_LO];
					ref_d.factoryTestFlag = shiftWord[`PSL_REF_TEST];
					ref_d.lockPrecisionSel = shiftWord[`PSL_REF_PRECISION];
					ref_d.antibacklashWidth = shiftWord[`PSL_REF_ABP_HI:`PSL_REF_ABP_LO];
					ref_d.referenceDivide = shiftWord[`PSL_REF_DIV_HI:`PSL_REF_DIV_LO];
				end
				default: begin
					// the fourth code addresses the factory test latch, which is ignored
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q <= '0;
			fb_q <= '0;
			ref_q <= '0;
			gain_q <= 1'b0;
		end else if (clkEn) begin
			cfg_q <= cfg_d;
			fb_q <= fb_d;
			ref_q <= ref_d;
			gain_q <= gain_d;
		end
	end

	// power-down sequencing
	psl_pd_e pdState_q, pdState_d;
	logic [1:0] pdEdges_q, pdEdges_d;
	logic refPulse_q, refPulse_d;
	logic downNow;

	always_comb begin
		pdState_d = pdState_q;
		pdEdges_d = pdEdges_q;
		case (pdState_q)
			PSL_RUN: begin
				pdEdges_d = 2'h0;
			end
			PSL_WAIT_REF: begin
				if (refPulse_q) begin
					pdEdges_d = pdEdges_q + 2'h1;
					if (pdEdges_q + 2'h1 == `PSL_SYNC_PD_EDGES) begin
						pdState_d = PSL_DOWN;
					end
				end
			end
			PSL_DOWN: begin
				pdEdges_d = 2'h0;
			end
			default: begin
				pdState_d = PSL_RUN;
			end
		endcase
		// every configuration write re-arms the sequence from the fresh bits, except a synchronous request while already down, which stays down
		if (loadRise && latchSel == `PSL_SEL_CONFIG) begin
			pdEdges_d = 2'h0;
			if (!shiftWord[`PSL_CFG_PD_REQ]) begin
				pdState_d = PSL_RUN;
			end else if (!shiftWord[`PSL_CFG_PD_MODE]) begin
				pdState_d = PSL_DOWN;
			end else if (pdState_q != PSL_DOWN) begin
				pdState_d = PSL_WAIT_REF;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pdState_q <= PSL_RUN;
			pdEdges_q <= 2'h0;
		end else if (clkEn) begin
			pdState_q <= pdState_d;
			pdEdges_q <= pdEdges_d;
		end
	end

	assign downNow = ~ceSync_q[1] | (pdState_q == PSL_DOWN);

	// reference and dual-modulus feedback counters
	logic [`PSL_REF_W-1:0] refCnt_q, refCnt_d;
	logic [`PSL_REF_W-1:0] mainCnt_q, mainCnt_d;
	logic [`PSL_SWALLOW_W-1:0] swallowCnt_q, swallowCnt_d;
	logic fbPulse_q, fbPulse_d;
	logic modHigh_q, modHigh_d;
	logic countersHeld;
	logic [`PSL_REF_W-1:0] refLimit;
	logic [`PSL_REF_W-1:0] mainLimit;

	assign countersHeld = downNow | cfg_q.dividerCountersClear;
	assign refLimit = (ref_q.referenceDivide == 14'h0000) ? 14'h0001 : ref_q.referenceDivide;
	assign mainLimit = {1'b0, fb_q.mainCount};

	always_comb begin
		refCnt_d = refCnt_q;
		mainCnt_d = mainCnt_q;
		swallowCnt_d = swallowCnt_q;
		refPulse_d = 1'b0;
		fbPulse_d = 1'b0;
		modHigh_d = swallowCnt_q < fb_q.swallowCount;
		if (countersHeld) begin
			refCnt_d = 14'h0000;
			mainCnt_d = 14'h0000;
			swallowCnt_d = 5'h00;
			modHigh_d = 1'b0;
		end else begin
			if (refEdge) begin
				refCnt_d = countNext(refCnt_q, refLimit);
				refPulse_d = (refCnt_d == 14'h0000);
			end
			if (preEdge) begin
				// swallow runs at the higher modulus; main spans the whole cycle
				if (swallowCnt_q < fb_q.swallowCount) begin
					swallowCnt_d = swallowCnt_q + 5'h01;
				end
				mainCnt_d = countNext(mainCnt_q, mainLimit);
				if (mainCnt_d == 14'h0000) begin
					fbPulse_d = 1'b1;
					swallowCnt_d = 5'h00;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refCnt_q <= 14'h0000;
			mainCnt_q <= 14'h0000;
			swallowCnt_q <= 5'h00;
			refPulse_q <= 1'b0;
			fbPulse_q <= 1'b0;
			modHigh_q <= 1'b0;
		end else if (clkEn) begin
			refCnt_q <= refCnt_d;
			mainCnt_q <= mainCnt_d;
			swallowCnt_q <= swallowCnt_d;
			refPulse_q <= refPulse_d;
			fbPulse_q <= fbPulse_d;
			modHigh_q <= modHigh_d;
		end
	end

	// digital lock detect: pulses from both sides inside the phase window count good
	logic refWait_q, refWait_d;
	logic fbWait_q, fbWait_d;
	logic [`PSL_PHASE_CNT_W-1:0] phaseCnt_q, phaseCnt_d;
	logic [2:0] goodCnt_q, goodCnt_d;
	logic locked_q, locked_d;
	logic [2:0] needCycles;

	assign needCycles = ref_q.lockPrecisionSel ? `PSL_LOCK_FINE : `PSL_LOCK_COARSE;

	always_comb begin
		refWait_d = refWait_q;
		fbWait_d = fbWait_q;
		phaseCnt_d = phaseCnt_q;
		goodCnt_d = goodCnt_q;
		locked_d = locked_q;
		if (countersHeld) begin
			refWait_d = 1'b0;
			fbWait_d = 1'b0;
			phaseCnt_d = '0;
			goodCnt_d = 3'h0;
			locked_d = 1'b0;
		end else if ((refPulse_q && fbPulse_q) || (refPulse_q && fbWait_q)
			|| (fbPulse_q && refWait_q)) begin
			refWait_d = 1'b0;
			fbWait_d = 1'b0;
			phaseCnt_d = '0;
			if (goodCnt_q < needCycles) begin
				goodCnt_d = goodCnt_q + 3'h1;
			end
			if (goodCnt_q + 3'h1 >= needCycles) begin
				locked_d = 1'b1;
			end
		end else if (refPulse_q || fbPulse_q) begin
			refWait_d = refPulse_q;
			fbWait_d = fbPulse_q;
			phaseCnt_d = '0;
		end else if (refWait_q || fbWait_q) begin
			if (phaseCnt_q + 4'h1 > `PSL_PHASE_CYCLES) begin
				refWait_d = 1'b0;
				fbWait_d = 1'b0;
				phaseCnt_d = '0;
				goodCnt_d = 3'h0;
				locked_d = 1'b0;
			end else begin
				phaseCnt_d = phaseCnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			refWait_q <= 1'b0;
			fbWait_q <= 1'b0;
			phaseCnt_q <= '0;
			goodCnt_q <= 3'h0;
			locked_q <= 1'b0;
		end else if (clkEn) begin
			refWait_q <= refWait_d;
			fbWait_q <= fbWait_d;
			phaseCnt_q <= phaseCnt_d;
			goodCnt_q <= goodCnt_d;
			locked_q <= locked_d;
		end
	end

	// registered outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			configImage <= '0;
			feedbackImage <= '0;
			referenceImage <= '0;
			pumpGainSelect <= 1'b0;
			pumpCurrent <= 3'h0;
			pumpTristate <= 1'b1;
			detectorPositive <= 1'b0;
			rfMute <= 1'b1;
			outputHalving <= 1'b0;
			halvedFeedbackSel <= 1'b0;
			modulusHigh <= 1'b0;
			referenceBufferEnable <= 1'b0;
			poweredDown <= 1'b1;
			referencePulse <= 1'b0;
			feedbackPulse <= 1'b0;
			lockDetect <= 1'b0;
		end else if (clkEn) begin
			configImage <= cfg_q;
			feedbackImage <= fb_q;
			referenceImage <= ref_q;
			pumpGainSelect <= gain_q;
			pumpCurrent <= gain_q ? cfg_q.pumpCurrentTwo : cfg_q.pumpCurrentOne;
			pumpTristate <= downNow | cfg_q.pumpThreeState;
			detectorPositive <= cfg_q.detectorPolarity;
			rfMute <= downNow | (cfg_q.muteUntilLocked & ~locked_q);
			outputHalving <= fb_q.outputHalving;
			halvedFeedbackSel <= fb_q.halvedFeedbackSel;
			modulusHigh <= modHigh_q;
			referenceBufferEnable <= ~downNow;
			poweredDown <= downNow;
			referencePulse <= refPulse_q;
			feedbackPulse <= fbPulse_q;
			lockDetect <= locked_q;
		end
	end

endmodule : psl_serial_latch

// [psl_serial_latch_asserts.sv]
// concurrent checks on the serial latch block's outputs and chip-enable pin
// assumes: bound into psl_serial_latch, with clkEn held high by the bench
`timescale 1ns/1ps
module psl_serial_latch_asserts
	import psl_pkg::*;
(
	// clock, reset and pin
	input wire logic clk,
	input wire logic reset,
	input wire logic chipEnable,
	// latch images
	input psl_cfg_s configImage,
	input psl_fb_s feedbackImage,
	input psl_ref_s referenceImage,
	// controls and status
	input wire logic pumpGainSelect,
	input wire logic [2:0] pumpCurrent,
	input wire logic pumpTristate,
	input wire logic detectorPositive,
	input wire logic rfMute,
	input wire logic outputHalving,
	input wire logic halvedFeedbackSel,
	input wire logic referenceBufferEnable,
	input wire logic poweredDown,
	input wire logic referencePulse,
	input wire logic feedbackPulse,
	input wire logic lockDetect
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// reference pulses seen while unlocked and running
	logic [3:0] refSeen_q, refSeen_d;
	always_comb begin
		refSeen_d = refSeen_q;
		if (reset || poweredDown || lockDetect) begin
			refSeen_d = 4'h0;
		end else if (referencePulse && refSeen_q != 4'hf) begin
			refSeen_d = refSeen_q + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		refSeen_q <= refSeen_d;
	end
	a_pump_current_sel: assert property (
		$stable({configImage, pumpGainSelect}) [*2] |-> pumpCurrent ==
		(pumpGainSelect ? configImage.pumpCurrentTwo : configImage.pumpCurrentOne))
		else $error("pump current does not follow gain select");
	a_down_effects: assert property (poweredDown [*2] |->
		pumpTristate && !referenceBufferEnable && !lockDetect && rfMute)
		else $error("power-down effects missing");
	a_down_no_pulse: assert property (poweredDown [*4] |->
		!referencePulse && !feedbackPulse)
		else $error("counter pulse while powered down");
	a_clear_holds: assert property (configImage.dividerCountersClear [*4] |->
		!referencePulse && !feedbackPulse)
		else $error("counter pulse while counters held clear");
	a_mute_until_lock: assert property (
		(configImage.muteUntilLocked && !lockDetect) [*2] |-> rfMute)
		else $error("outputs on before lock");
	a_polarity_map: assert property (
		$stable(configImage.detectorPolarity) [*2] |-> detectorPositive == configImage.detectorPolarity)
		else $error("polarity output wrong");
	a_halving_map: assert property (
		$stable(feedbackImage.outputHalving) [*2] |-> outputHalving == feedbackImage.outputHalving)
		else $error("halving output wrong");
	a_halved_sel_map: assert property ($stable(feedbackImage) [*2] |->
		halvedFeedbackSel == feedbackImage.halvedFeedbackSel)
		else $error("prescaler source wrong");
	a_enable_low_down: assert property (!chipEnable [*6] |-> poweredDown)
		else $error("chip enable low but running");
	a_async_down: assert property ($rose(configImage.powerdownRequest) &&
		!configImage.powerdownSyncMode |-> ##[0:3] poweredDown)
		else $error("asynchronous power-down late");
	a_lock_count: assert property ($rose(lockDetect) |->
		refSeen_q >= (referenceImage.lockPrecisionSel ? 4'h4 : 4'h2))
		else $error("lock declared too early");
endmodule : psl_serial_latch_asserts

bind psl_serial_latch psl_serial_latch_asserts chk (.clk, .reset, .chipEnable, .configImage,
	.feedbackImage, .referenceImage, .pumpGainSelect, .pumpCurrent, .pumpTristate,
	.detectorPositive, .rfMute, .outputHalving, .halvedFeedbackSel, .referenceBufferEnable,
	.poweredDown, .referencePulse, .feedbackPulse, .lockDetect);

// [psl_host_model.sv]
// host serial master: shifts one 24-bit word, then pulses the load strobe
// assumes: start rises once per word and word holds until done
`timescale 1ns/1ps
module psl_host_model (
	// request from the bench
	input wire logic start,
	input wire logic [23:0] word,
	output logic done,
	// three-wire link
	output logic serialClk,
	output logic serialData,
	output logic loadStrobe
);
	initial begin
		done = 1'b0;
		serialClk = 1'b0;
		serialData = 1'b0;
		loadStrobe = 1'b0;
		forever begin
			@(posedge start);
			done = 1'b0;
			#1.7;
			// link clock runs only inside the frame
			for (int i = 23; i >= 0; i--) begin
				serialData = word[i];
				#6 serialClk = 1'b1;
				#6 serialClk = 1'b0;
			end
			// data no longer held after the last bit
			serialData = ~serialData;
			loadStrobe = 1'b1;
			#60 loadStrobe = 1'b0;
			#30 done = 1'b1;
		end
	end
endmodule : psl_host_model

// [psl_serial_latch_bench.sv]
// self-checking bench: host model writes words, bench drives pins and checks outputs
// assumes: package, design, host model and checker compiled before this file
`timescale 1ns/1ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t %s", $time, m); end end
module psl_serial_latch_bench
	import psl_pkg::*;
;
	logic clk, reset, clkEn, serialClk, serialData, loadStrobe, chipEnable, refIn, prescalerIn;
	logic pumpGainSelect, pumpTristate, detectorPositive, rfMute, outputHalving;
	logic halvedFeedbackSel, referenceBufferEnable, poweredDown, referencePulse;
	logic feedbackPulse, lockDetect, hostStart, hostDone, expGain, modulusHigh;
	logic [2:0] pumpCurrent;
	logic [23:0] hostWord, c, r, f;
	psl_cfg_s configImage, expCfg;
	psl_fb_s feedbackImage, expFb;
	psl_ref_s referenceImage, expRef;
	int fails, comparisons;

	psl_serial_latch dut (.clk, .reset, .clkEn, .serialClk, .serialData, .loadStrobe,
		.chipEnable, .refIn, .prescalerIn, .configImage, .feedbackImage, .referenceImage,
		.pumpGainSelect, .pumpCurrent, .pumpTristate, .detectorPositive, .rfMute,
		.outputHalving, .halvedFeedbackSel, .modulusHigh, .referenceBufferEnable,
		.poweredDown, .referencePulse, .feedbackPulse, .lockDetect);
	psl_host_model host (.start(hostStart), .word(hostWord), .done(hostDone), .serialClk,
		.serialData, .loadStrobe);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic psl_cfg_s cfg_of(input logic [23:0] x);
		return {x[23:11], x[9:2]};
	endfunction : cfg_of
	function automatic psl_fb_s fb_of(input logic [23:0] x);
		return {x[23:22], x[20:8], x[6:2]};
	endfunction : fb_of

	task automatic stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// one word over the link, then all images against the shadow copies
	task automatic put(input logic [23:0] x);
		int n;
		n = 0;
		hostWord = x;
		hostStart = 1'b1;
		@(negedge clk);
		while (hostDone !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		hostStart = 1'b0;
		if (n >= 200) begin
			fails++;
			$display("[FAIL] %0t host word not finished", $time);
			stop_test();
		end
		if (x[1:0] == 2'h0) begin
			expCfg = cfg_of(x);
			expGain = x[10];
		end else if (x[1:0] == 2'h2) begin
			expFb = fb_of(x);
			expGain = x[21];
		end else if (x[1:0] == 2'h1) begin
			expRef = x[21:2];
		end
		@(negedge clk);
		`CHK(configImage, expCfg, "configuration image")
		`CHK(feedbackImage, expFb, "feedback image")
		`CHK(referenceImage, expRef, "reference image")
		`CHK(pumpGainSelect, expGain, "gain select")
		`CHK(pumpCurrent, expGain ? expCfg.pumpCurrentTwo : expCfg.pumpCurrentOne, "pump current")
		`CHK(detectorPositive, expCfg.detectorPolarity, "detector polarity")
		`CHK(outputHalving, expFb.outputHalving, "output halving")
		`CHK(halvedFeedbackSel, expFb.halvedFeedbackSel, "prescaler source")
	endtask : put

	task automatic pulses(input int n, input logic fb);
		repeat (n) begin
			refIn = 1'b1;
			prescalerIn = fb;
			repeat (2) @(negedge clk);
			refIn = 1'b0;
			prescalerIn = 1'b0;
			repeat (2) @(negedge clk);
		end
	endtask : pulses

	task automatic wait_down(input logic v);
		int n;
		n = 0;
		while (poweredDown !== v && n < 20) begin
			@(negedge clk);
			n++;
		end
		`CHK(poweredDown, v, "power state after chip enable change")
		if (n >= 20) begin
			stop_test();
		end
	endtask : wait_down

	initial begin
		#1_000_000;
		fails++;
		$display("[FAIL] %0t run limit reached", $time);
		stop_test();
	end

	initial begin
		{reset, clkEn, chipEnable} = 3'h7;
		{refIn, prescalerIn, hostStart, expGain} = 4'h0;
		hostWord = 24'h00_0000;
		{expCfg, expFb, expRef} = '0;
		fails = 0;
		comparisons = 0;
		void'($urandom(78743));
		repeat (20) @(negedge clk);
		reset = 1'b0;
		// reference, configuration, feedback, with a pause before feedback
		r = 24'($urandom) & 24'h37_0001 | 24'h00_000d;
		c = 24'($urandom) & 24'hc3_f1ec;
		f = 24'($urandom) & 24'he0_007c | 24'h00_0302;
		put(r);
		put(c | 24'h00_0800);
		repeat (50) @(negedge clk);
		put(f);
		put(24'($urandom) | 24'h00_0003);
		`CHK(rfMute, 1'b1, "outputs on before lock")
		pulses(24, 1'b1);
		`CHK(lockDetect, 1'b1, "no lock with aligned edges")
		`CHK(rfMute, 1'b0, "outputs muted after lock")
		repeat (2) @(negedge clk);
		`CHK(modulusHigh, f[6:2] != 5'h00, "modulus control at cycle start")
		put(c | 24'h10_0800);
		`CHK(poweredDown, 1'b1, "asynchronous power-down")
		`CHK(lockDetect, 1'b0, "lock kept in power-down")
		`CHK(pumpTristate, 1'b1, "pump driven in power-down")
		`CHK(referenceBufferEnable, 1'b0, "reference buffer on")
		put(r ^ 24'h04_0000);
		put(c);
		`CHK(poweredDown, 1'b0, "power-up by configuration")
		put(c | 24'h30_0000);
		pulses(3, 1'b0);
		repeat (4) @(negedge clk);
		`CHK(poweredDown, 1'b0, "synchronous power-down early")
		pulses(3, 1'b0);
		repeat (6) @(negedge clk);
		`CHK(poweredDown, 1'b1, "synchronous power-down missing")
		put(c);
		chipEnable = 1'b0;
		wait_down(1'b1);
		repeat (8) @(negedge clk);
		`CHK(poweredDown, 1'b1, "running while chip enable low")
		chipEnable = 1'b1;
		wait_down(1'b0);
		put(c | 24'h00_0010);
		pulses(24, 1'b1);
		`CHK(lockDetect, 1'b0, "lock while counters held")
		repeat (6) begin
			r = 24'($urandom) & 24'h37_fffc | 24'h00_0005;
			c = 24'($urandom) & 24'hcf_fffc;
			f = 24'($urandom) & 24'hff_ff7c | 24'h00_0302;
			put(r);
			put(c);
			put(f);
		end
		stop_test();
	end
endmodule : psl_serial_latch_bench
